/* File: logic/psm_pkg.sv */
// package of constants and types for the phy strap and pin function mux
package psm_pkg;

    // register bus
    localparam int unsigned PSM_ADDR_W = 5;
    localparam int unsigned PSM_DATA_W = 16;
    localparam logic [4:0] PSM_REG_STRAP = 5'h18;
    localparam logic [4:0] PSM_REG_IRQ   = 5'h1B;
    localparam logic [4:0] PSM_REG_CTRL  = 5'h1F;

    // interrupt control/status layout: status low byte, enables high byte
    localparam int unsigned PSM_IRQ_EVENTS = 8;
    localparam int unsigned PSM_IRQ_ST_LSB = 0;
    localparam int unsigned PSM_IRQ_EN_LSB = 8;

    // control register fields
    localparam int unsigned PSM_CTRL_POL_BIT = 9;
    localparam int unsigned PSM_CTRL_PME_BIT = 10;
    localparam logic        PSM_CTRL_POL_RST = 1'b0;
    localparam logic        PSM_CTRL_PME_RST = 1'b0;

    // strap readback register fields
    localparam int unsigned PSM_ST_ADDR_LSB  = 0;
    localparam int unsigned PSM_ST_DUPLEX    = 3;
    localparam int unsigned PSM_ST_MODE2     = 4;
    localparam int unsigned PSM_ST_BCAST     = 5;
    localparam int unsigned PSM_ST_ISOLATE   = 6;
    localparam int unsigned PSM_ST_NAND_N    = 7;
    localparam int unsigned PSM_ST_WAKE_EN   = 8;
    localparam int unsigned PSM_ST_WAKE_PEND = 15;

    // cycles after reset release before the straps are taken
    localparam logic [1:0] PSM_SETTLE_CYCLES = 2'h3;

    typedef enum logic [0:0] {
        PSM_SETTLE,
        PSM_RUN
    } psm_fsm_t;

    typedef struct packed {
        logic [3:0] rxd;
        logic       rxdv;
        logic       rxer;
    } psm_mii_rx_t;

    typedef struct packed {
        logic [3:0] rxd;
        logic       rxdv;
        logic       rxc;
        logic       rxer;
        logic       txc;
        logic       intp;
    } psm_pin_t;

    typedef struct packed {
        logic        rx_clk;
        logic        tx_clk;
        psm_mii_rx_t rx;
    } psm_link_t;

    typedef struct packed {
        logic [2:0] phy_management_address;
        logic       duplex;
        logic       mode_select_bit2_strap;
        logic       broadcast_address_disable_strap;
        logic       isolate;
        logic       nand_tree_n;
        logic       wake_event_output_enable;
    } psm_strap_t;

endpackage

/* File: logic/psm_pin_mux.sv */
// strap capture and mii pin function mux with open-drain interrupt/wake pin
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
//
// Summary of operation
// RULE1: at reset release take rxd2 pin as address bit 1, rxd1 as bit 2
// RULE2: at reset release take rxd0 pin level as duplex setting
// RULE3: at reset release take rxdv pin level as mode select bit 2
// RULE4: at reset release take rxc pin level as broadcast address disable
// RULE5: at reset release take rxer pin level as isolate setting
// RULE6: at reset release take interrupt pin level as active-low nand tree select
// RULE7: at reset release take txc pin level as wake output enable
// RULE8: after reset drive receive data bits 2, 1, 0 toward the mac
// RULE9: after reset drive receive data valid on the mode bit 2 pin
// RULE10: after reset drive receive clock on the broadcast strap pin
// RULE11: after reset drive receive error on the isolate strap pin
// RULE12: after reset drive transmit clock on the wake enable strap pin
// RULE13: interrupt follows conditions set in register 1Bh, which also reports status
// RULE14: interrupt polarity from bit 9 of 1Fh, low by default
// RULE15: in wake function, pin is pulled low when a wake event occurred
// RULE16: interrupt/wake pin is open drain, only ever pulls low
// RULE17: at reset release take rxd3 pin level as address bit 0
// RULE18: receive data follow receive clock and are valid only with data valid
// RULE19: straps hold until next reset; strap pins undriven during reset
module psm_pin_mux
    import psm_pkg::*;
(
    // clock and reset
    input  wire logic                  core_clk_in,
    input  wire logic                  rst_n_in,
    // register port
    input  wire logic [PSM_ADDR_W-1:0] reg_addr_in,
    input  wire logic [PSM_DATA_W-1:0] reg_wdata_in,
    input  wire logic                  reg_wr_in,
    input  wire logic                  reg_rd_in,
    output logic      [PSM_DATA_W-1:0] reg_rdata_out,
    // phy core side, receive and transmit clock domains
    input  wire logic                  rx_link_clk_in,
    input  wire logic                  tx_link_clk_in,
    input  wire psm_mii_rx_t           rx_link_in,
    // phy core side, core clock domain
    input  wire logic [PSM_IRQ_EVENTS-1:0] irq_event_in,
    input  wire logic                  wake_event_in,
    // mii receive pins, shared with straps
    input  wire psm_pin_t              pin_in,
    output psm_pin_t                   pin_out,
    output psm_pin_t                   pin_oe_out,
    // captured straps and interrupt
    output psm_strap_t                 strap_out,
    output logic                       straps_valid_out,
    output logic                       interrupt_request_out
);

    typedef struct packed {
        psm_fsm_t                  fsm;
        logic [1:0]                settle_cnt;
        psm_pin_t                  pin_s1;
        psm_pin_t                  pin_s2;
        psm_link_t                 lnk_s1;
        psm_link_t                 lnk_s2;
        logic                      rx_clk_d;
        psm_mii_rx_t               rx_drv;
        logic                      rxc_drv;
        logic                      txc_drv;
        psm_strap_t                strap;
        logic [PSM_IRQ_EVENTS-1:0] irq_status;
        logic [PSM_IRQ_EVENTS-1:0] irq_enable;
        logic                      wake_pending;
        logic                      irq_pol;
        logic                      pme_sel;
        logic                      pin_low;
        logic [PSM_DATA_W-1:0]     rdata;
    } psm_state_t;

    localparam psm_state_t PSM_STATE_RST = '{
        fsm:          PSM_SETTLE,
        settle_cnt:   2'h0,
        pin_s1:       '0,
        pin_s2:       '0,
        lnk_s1:       '0,
        lnk_s2:       '0,
        rx_clk_d:     1'b0,
        rx_drv:       '0,
        rxc_drv:      1'b0,
        txc_drv:      1'b0,
        strap:        '0,
        irq_status:   '0,
        irq_enable:   '0,
        wake_pending: 1'b0,
        irq_pol:      PSM_CTRL_POL_RST,
        pme_sel:      PSM_CTRL_PME_RST,
        pin_low:      1'b0,
        rdata:        '0
    };

    function automatic logic reg_hit(input logic [PSM_ADDR_W-1:0] addr,
                                     input logic [PSM_ADDR_W-1:0] offset);
        reg_hit = (addr == offset);
    endfunction

    logic [1:0]  rst_sync_r;
    logic        rst_n;
    psm_state_t  st_r;
    psm_state_t  st_nxt;
    logic        irq_active;
    logic [PSM_DATA_W-1:0] rd_value;

    // reset is applied at once but released through two flops
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_r[1];

    assign irq_active = |(st_r.irq_status & st_r.irq_enable); // see RULE13

    // register read mux
    always_comb begin
        rd_value = '0;
        if (reg_hit(reg_addr_in, PSM_REG_IRQ)) begin
            rd_value[PSM_IRQ_ST_LSB +: PSM_IRQ_EVENTS] = st_r.irq_status; // see RULE13
            rd_value[PSM_IRQ_EN_LSB +: PSM_IRQ_EVENTS] = st_r.irq_enable;
        end else if (reg_hit(reg_addr_in, PSM_REG_CTRL)) begin
            rd_value[PSM_CTRL_POL_BIT] = st_r.irq_pol;
            rd_value[PSM_CTRL_PME_BIT] = st_r.pme_sel;
        end else if (reg_hit(reg_addr_in, PSM_REG_STRAP)) begin
            rd_value[PSM_ST_ADDR_LSB +: 3] = st_r.strap.phy_management_address;
            rd_value[PSM_ST_DUPLEX]        = st_r.strap.duplex;
            rd_value[PSM_ST_MODE2]         = st_r.strap.mode_select_bit2_strap;
            rd_value[PSM_ST_BCAST]         = st_r.strap.broadcast_address_disable_strap;
            rd_value[PSM_ST_ISOLATE]       = st_r.strap.isolate;
            rd_value[PSM_ST_NAND_N]        = st_r.strap.nand_tree_n;
            rd_value[PSM_ST_WAKE_EN]       = st_r.strap.wake_event_output_enable;
            rd_value[PSM_ST_WAKE_PEND]     = st_r.wake_pending;
        end
    end

    always_comb begin
        st_nxt = st_r;

        // two-flop synchronisers for pins and the phy core receive domain
        st_nxt.pin_s1   = pin_in;
        st_nxt.pin_s2   = st_r.pin_s1;
        st_nxt.lnk_s1   = '{rx_clk: rx_link_clk_in, tx_clk: tx_link_clk_in, rx: rx_link_in};
        st_nxt.lnk_s2   = st_r.lnk_s1;
        st_nxt.rx_clk_d = st_r.lnk_s2.rx_clk;

        case (st_r.fsm)
            PSM_SETTLE: begin
                // pins stay inputs until straps have passed the synchronisers
                if (st_r.settle_cnt == PSM_SETTLE_CYCLES) begin
                    st_nxt.strap.phy_management_address[0] = st_r.pin_s2.rxd[3]; // see RULE17
                    st_nxt.strap.phy_management_address[1] = st_r.pin_s2.rxd[2]; // see RULE1
                    st_nxt.strap.phy_management_address[2] = st_r.pin_s2.rxd[1]; // see RULE1
                    st_nxt.strap.duplex                    = st_r.pin_s2.rxd[0]; // see RULE2
                    st_nxt.strap.mode_select_bit2_strap    = st_r.pin_s2.rxdv;   // see RULE3
                    st_nxt.strap.broadcast_address_disable_strap = st_r.pin_s2.rxc; // see RULE4
                    st_nxt.strap.isolate                   = st_r.pin_s2.rxer;   // see RULE5
                    st_nxt.strap.nand_tree_n               = st_r.pin_s2.intp;   // see RULE6
                    st_nxt.strap.wake_event_output_enable  = st_r.pin_s2.txc;    // see RULE7
                    st_nxt.fsm = PSM_RUN;
                end else begin
                    st_nxt.settle_cnt = st_r.settle_cnt + 2'h1;
                end
            end
            PSM_RUN: begin
                // straps are not touched again until the next reset, see RULE19
                // launch on the falling receive clock so data are stable at the rising
                if (st_r.rx_clk_d && !st_r.lnk_s2.rx_clk) begin
                    st_nxt.rx_drv.rxdv = st_r.lnk_s2.rx.rxdv; // see RULE18
                    st_nxt.rx_drv.rxer = st_r.lnk_s2.rx.rxer;
                    st_nxt.rx_drv.rxd  = st_r.lnk_s2.rx.rxdv ? st_r.lnk_s2.rx.rxd : 4'h0; // see RULE18
                end
                st_nxt.rxc_drv = st_r.lnk_s2.rx_clk; // see RULE10
                st_nxt.txc_drv = st_r.lnk_s2.tx_clk; // see RULE12
            end
            default: begin
                st_nxt.fsm = PSM_SETTLE;
            end
        endcase

        // register writes; a new event wins over a write-one clear
        if (reg_wr_in && reg_hit(reg_addr_in, PSM_REG_IRQ)) begin
            st_nxt.irq_status = st_r.irq_status
                              & ~reg_wdata_in[PSM_IRQ_ST_LSB +: PSM_IRQ_EVENTS];
            st_nxt.irq_enable = reg_wdata_in[PSM_IRQ_EN_LSB +: PSM_IRQ_EVENTS]; // see RULE13
        end
        if (reg_wr_in && reg_hit(reg_addr_in, PSM_REG_CTRL)) begin
            st_nxt.irq_pol = reg_wdata_in[PSM_CTRL_POL_BIT]; // see RULE14
            st_nxt.pme_sel = reg_wdata_in[PSM_CTRL_PME_BIT];
        end
        if (reg_wr_in && reg_hit(reg_addr_in, PSM_REG_STRAP)
                && reg_wdata_in[PSM_ST_WAKE_PEND]) begin
            st_nxt.wake_pending = 1'b0;
        end
        st_nxt.irq_status = st_nxt.irq_status | irq_event_in; // see RULE13
        if (wake_event_in) begin
            st_nxt.wake_pending = 1'b1;
        end

        // open-drain pin: only ever pulled low, see RULE16
        if (st_r.pme_sel) begin
            st_nxt.pin_low = st_r.wake_pending
                           & st_r.strap.wake_event_output_enable; // see RULE15
        end else begin
            st_nxt.pin_low = st_r.irq_pol ? !irq_active : irq_active; // see RULE14
        end

        // read data stand only in the cycle after the read strobe
        st_nxt.rdata = reg_rd_in ? rd_value : '0;
    end

    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= PSM_STATE_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // pin drive; isolate releases the mac-side outputs
    always_comb begin
        logic drive_mii;
        drive_mii          = (st_r.fsm == PSM_RUN) && !st_r.strap.isolate; // see RULE19
        pin_out            = '0;
        pin_out.rxd        = st_r.rx_drv.rxd;  // see RULE8
        pin_out.rxdv       = st_r.rx_drv.rxdv; // see RULE9
        pin_out.rxer       = st_r.rx_drv.rxer; // see RULE11
        pin_out.rxc        = st_r.rxc_drv;     // see RULE10
        pin_out.txc        = st_r.txc_drv;     // see RULE12
        pin_out.intp       = 1'b0;             // see RULE16
        pin_oe_out         = '0;
        pin_oe_out.rxd     = {4{drive_mii}};
        pin_oe_out.rxdv    = drive_mii;
        pin_oe_out.rxer    = drive_mii;
        pin_oe_out.rxc     = drive_mii;
        pin_oe_out.txc     = drive_mii;
        pin_oe_out.intp    = (st_r.fsm == PSM_RUN) && st_r.pin_low; // see RULE16
    end

    assign reg_rdata_out         = st_r.rdata;
    assign strap_out             = st_r.strap;
    assign straps_valid_out      = (st_r.fsm == PSM_RUN);
    assign interrupt_request_out = irq_active;

endmodule // psm_pin_mux

/* File: tb/psm_pin_mux_properties.sv */
// concurrent checks on the ports of the strap and pin function mux
`timescale 1ns/100ps
module psm_pin_mux_checker
    import psm_pkg::*;
(
    // clock, reset and register port
    input wire logic                      core_clk_in,
    input wire logic                      rst_n_in,
    input wire logic [PSM_ADDR_W-1:0]     reg_addr_in,
    input wire logic [PSM_DATA_W-1:0]     reg_wdata_in,
    input wire logic                      reg_wr_in,
    input wire logic                      reg_rd_in,
    input wire logic [PSM_DATA_W-1:0]     reg_rdata_out,
    // core side
    input wire logic                      rx_link_clk_in,
    input wire logic                      tx_link_clk_in,
    input wire psm_mii_rx_t               rx_link_in,
    input wire logic [PSM_IRQ_EVENTS-1:0] irq_event_in,
    input wire logic                      wake_event_in,
    // pins, straps and interrupt
    input wire psm_pin_t                  pin_in,
    input wire psm_pin_t                  pin_out,
    input wire psm_pin_t                  pin_oe_out,
    input wire psm_strap_t                strap_out,
    input wire logic                      straps_valid_out,
    input wire logic                      interrupt_request_out
);
    logic pol_r;
    logic pme_r;
    logic irq_wr_w;
    psm_pin_t pin_d1;
    psm_pin_t pin_d2;
    psm_pin_t pin_d3;
    // shadow of the control bits, so pin checks need no internal probes
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pol_r <= PSM_CTRL_POL_RST;
            pme_r <= PSM_CTRL_PME_RST;
        end else if (reg_wr_in && reg_addr_in == PSM_REG_CTRL) begin
            pol_r <= reg_wdata_in[PSM_CTRL_POL_BIT];
            pme_r <= reg_wdata_in[PSM_CTRL_PME_BIT];
        end
    end
    assign irq_wr_w = reg_wr_in && reg_addr_in == PSM_REG_IRQ;
    // pin levels as the capture edge saw them; the mii pins are already driven when valid rises unless isolate is strapped
    always_ff @(posedge core_clk_in) begin
        pin_d1 <= pin_in;
        pin_d2 <= pin_d1;
        pin_d3 <= pin_d2;
    end

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);

    AST_UNDRIVEN_BEFORE_VALID: assert property (!straps_valid_out |-> pin_oe_out == '0)
        else $error("pin driven before straps captured");
    AST_STRAP_CAPTURE: assert property ($rose(straps_valid_out) |-> strap_out ==
        {pin_d3.rxd[1], pin_d3.rxd[2], pin_d3.rxd[3], pin_d3.rxd[0], pin_d3.rxdv,
         pin_d3.rxc, pin_d3.rxer, pin_d3.intp, pin_d3.txc})
        else $error("captured straps differ from pin levels");
    AST_STRAP_HOLD: assert property (straps_valid_out |=> $stable(strap_out))
        else $error("strap value changed after capture");
    AST_INTP_OPEN_DRAIN: assert property (pin_out.intp == 1'b0)
        else $error("interrupt pin driven high");
    AST_ISOLATE_RELEASE: assert property (strap_out.isolate |-> {pin_oe_out.rxd, pin_oe_out.rxdv,
        pin_oe_out.rxc, pin_oe_out.rxer, pin_oe_out.txc} == 8'h00)
        else $error("mii pin driven while isolated");
    AST_MII_DRIVEN: assert property (straps_valid_out && !strap_out.isolate && strap_out.nand_tree_n
        |-> &{pin_oe_out.rxd, pin_oe_out.rxdv, pin_oe_out.rxc, pin_oe_out.rxer, pin_oe_out.txc})
        else $error("mii pin not driven after reset");
    AST_RXC_FOLLOW: assert property ($rose(rx_link_clk_in) && pin_oe_out.rxc
        |-> ##[2:4] $rose(pin_out.rxc)) else $error("receive clock pin does not follow");
    AST_TXC_FOLLOW: assert property ($rose(tx_link_clk_in) && pin_oe_out.txc
        |-> ##[2:4] $rose(pin_out.txc)) else $error("transmit clock pin does not follow");
    AST_RXD_QUIET: assert property (pin_oe_out.rxdv && !pin_out.rxdv |-> pin_out.rxd == 4'h0)
        else $error("receive data not zero while data valid low");
    AST_IRQ_CAUSE: assert property ($rose(interrupt_request_out) |->
        $past(irq_event_in) != 8'h00 || $past(irq_wr_w)) else $error("interrupt without cause");
    AST_IRQ_PIN: assert property (straps_valid_out && $past(straps_valid_out) && !$past(pme_r)
        && strap_out.nand_tree_n |-> pin_oe_out.intp == ($past(interrupt_request_out) ^ $past(pol_r)))
        else $error("interrupt pin level wrong for polarity");
    AST_WAKE_PIN: assert property (wake_event_in && straps_valid_out && pme_r
        && strap_out.wake_event_output_enable |-> ##[1:3] pin_oe_out.intp)
        else $error("wake event not signalled on pin");
    COV_IRQ: cover property ($rose(interrupt_request_out));
    COV_WAKE: cover property (pme_r && pin_oe_out.intp);
    COV_RXDV: cover property (pin_oe_out.rxdv && pin_out.rxdv);
endmodule // psm_pin_mux_checker

bind psm_pin_mux psm_pin_mux_checker psm_pin_mux_checker_i (.core_clk_in, .rst_n_in,
    .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .rx_link_clk_in,
    .tx_link_clk_in, .rx_link_in, .irq_event_in, .wake_event_in, .pin_in, .pin_out,
    .pin_oe_out, .strap_out, .straps_valid_out, .interrupt_request_out);

/* File: tb/psm_mac_model.sv */
// mac-side model: board pulls, pin wire levels and receive nibble capture
`timescale 1ns/100ps
module psm_mac_model
    import psm_pkg::*;
(
    // pin side
    input  wire psm_pin_t    pull_in,
    input  wire psm_pin_t    drive_in,
    input  wire psm_pin_t    oe_in,
    output psm_pin_t         wire_out,
    // captured receive stream
    output logic [15:0]      rx_word_out,
    output logic [3:0]       rx_cnt_out
);
    // a released line falls back to its pull, never keeps the old level
    assign wire_out = (oe_in & drive_in) | (~oe_in & pull_in);
    initial begin
        rx_word_out = 16'h0000;
        rx_cnt_out = 4'h0;
    end
    // sample on the rising receive clock, as a real mac does
    always @(posedge wire_out.rxc) begin
        if (wire_out.rxdv) begin
            rx_word_out <= {rx_word_out[11:0], wire_out.rxd};
            rx_cnt_out <= rx_cnt_out + 4'h1;
        end
    end
endmodule // psm_mac_model

/* File: tb/test_psm_pin_mux.sv */
// self-checking bench for the strap capture and pin function mux
`timescale 1ns/100ps
module test_psm_pin_mux;
    import psm_pkg::*;
    localparam psm_pin_t PAT_A = 9'h153;
    localparam psm_pin_t PAT_B = 9'h0AC;
    logic                  core_clk_in = 1'b0;
    logic                  rst_n_in = 1'b0;
    logic [PSM_ADDR_W-1:0] reg_addr_in = '0;
    logic [PSM_DATA_W-1:0] reg_wdata_in = '0;
    logic                  reg_wr_in = 1'b0;
    logic                  reg_rd_in = 1'b0;
    logic                  rx_link_clk_in = 1'b0;
    logic                  tx_link_clk_in = 1'b0;
    psm_mii_rx_t           rx_link_in = '0;
    logic [7:0]            irq_event_in = 8'h00;
    logic                  wake_event_in = 1'b0;
    psm_pin_t              pull = PAT_B;
    psm_pin_t              pin_in, pin_out, pin_oe_out;
    psm_strap_t            strap_out;
    logic                  straps_valid_out, interrupt_request_out;
    logic [15:0]           reg_rdata_out, rx_word;
    logic [3:0]            rx_cnt;
    logic [2:0]            lnk_cnt = 3'h0;
    int                    n_mismatch = 0;
    int                    comparisons = 0;

    always #12.5 core_clk_in = ~core_clk_in;
    // both link clocks 200 ns, transmit a quarter period ahead
    always @(posedge core_clk_in) begin
        lnk_cnt <= lnk_cnt + 3'h1;
        rx_link_clk_in <= lnk_cnt[2];
        tx_link_clk_in <= lnk_cnt[2] ^ lnk_cnt[1];
    end
    psm_pin_mux psm_pin_mux_i (.core_clk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in,
        .reg_wr_in, .reg_rd_in, .reg_rdata_out, .rx_link_clk_in, .tx_link_clk_in,
        .rx_link_in, .irq_event_in, .wake_event_in, .pin_in, .pin_out, .pin_oe_out,
        .strap_out, .straps_valid_out, .interrupt_request_out);
    psm_mac_model psm_mac_model_i (.pull_in(pull), .drive_in(pin_out), .oe_in(pin_oe_out),
        .wire_out(pin_in), .rx_word_out(rx_word), .rx_cnt_out(rx_cnt));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("mismatches=%0d comparisons=%0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge core_clk_in);
        #1;
    endtask
    task automatic reg_wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge core_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge core_clk_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic reg_rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge core_clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge core_clk_in);
        reg_rd_in <= 1'b0;
        #1 d = reg_rdata_out;
    endtask
    function automatic logic [8:0] strap_of(input psm_pin_t p);
        return {p.rxd[1], p.rxd[2], p.rxd[3], p.rxd[0], p.rxdv, p.rxc, p.rxer, p.intp, p.txc};
    endfunction

    task automatic test_reset_straps(input psm_pin_t p);
        logic [15:0] d;
        logic [8:0]  s;
        s = strap_of(p);
        @(posedge core_clk_in);
        pull <= p;
        rst_n_in <= 1'b0;
        settle(20);
        check(16'(pin_oe_out), 16'h0000);
        @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        for (int i = 0; i < 20 && straps_valid_out !== 1'b1; i++) settle(1);
        check(16'(strap_out), 16'(s));
        check(16'({pin_oe_out.rxd, pin_oe_out.rxdv, pin_oe_out.rxc, pin_oe_out.rxer,
            pin_oe_out.txc}), p.rxer ? 16'h0000 : 16'h00FF);
        reg_rd(PSM_REG_STRAP, d);
        check(d, {7'h00, s[0], s[1], s[2], s[3], s[4], s[5], s[8:6]});
    endtask
    task automatic test_irq();
        logic [15:0] d;
        reg_wr(PSM_REG_IRQ, 16'h0100);
        @(posedge core_clk_in) irq_event_in <= 8'h02;
        @(posedge core_clk_in) irq_event_in <= 8'h00;
        settle(2);
        check(16'({interrupt_request_out, pin_oe_out.intp}), 16'h0000);
        @(posedge core_clk_in) irq_event_in <= 8'h01;
        @(posedge core_clk_in) irq_event_in <= 8'h00;
        settle(2);
        check(16'({interrupt_request_out, pin_oe_out.intp}), 16'h0003);
        reg_rd(PSM_REG_IRQ, d);
        check(d, 16'h0103);
        settle(1);
        check(reg_rdata_out, 16'h0000);
        reg_wr(PSM_REG_CTRL, 16'h0200);
        settle(2);
        check(16'(pin_oe_out.intp), 16'h0000);
        reg_wr(PSM_REG_IRQ, 16'h0103);
        settle(2);
        check(16'({interrupt_request_out, pin_oe_out.intp}), 16'h0001);
        reg_wr(PSM_REG_CTRL, 16'h0000);
        settle(2);
        check(16'(pin_oe_out.intp), 16'h0000);
        reg_rd(5'h03, d);
        check(d, 16'h0000);
        // an event in the cycle of its own clear must survive
        @(posedge core_clk_in) irq_event_in <= 8'h01;
        reg_wr(PSM_REG_IRQ, 16'h0101);
        irq_event_in <= 8'h00;
        settle(1);
        check(16'(interrupt_request_out), 16'h0001);
        reg_wr(PSM_REG_IRQ, 16'h0001);
        settle(1);
        check(16'(interrupt_request_out), 16'h0000);
    endtask
    task automatic test_wake();
        logic [15:0] d;
        reg_wr(PSM_REG_CTRL, 16'h0400);
        settle(2);
        check(16'(pin_oe_out.intp), 16'h0000);
        @(posedge core_clk_in) wake_event_in <= 1'b1;
        @(posedge core_clk_in) wake_event_in <= 1'b0;
        settle(3);
        check(16'(pin_oe_out.intp), 16'h0001);
        reg_rd(PSM_REG_STRAP, d);
        check(16'(d[PSM_ST_WAKE_PEND]), 16'h0001);
        reg_wr(PSM_REG_STRAP, 16'h8000);
        settle(2);
        check(16'(pin_oe_out.intp), 16'h0000);
        reg_wr(PSM_REG_CTRL, 16'h0000);
    endtask
    task automatic test_rx();
        logic [3:0]  c0;
        logic [15:0] nib;
        nib = 16'h1A5F;
        c0 = rx_cnt;
        for (int i = 3; i >= 0; i--) begin
            @(posedge rx_link_clk_in);
            rx_link_in <= '{rxd: nib[i*4 +: 4], rxdv: 1'b1, rxer: 1'b0};
        end
        @(posedge rx_link_clk_in);
        rx_link_in <= '{rxd: 4'hC, rxdv: 1'b0, rxer: 1'b1};
        repeat (2) @(posedge rx_link_clk_in);
        settle(1);
        check(16'(rx_cnt - c0), 16'h0004);
        check(rx_word, nib);
        check(16'(pin_out.rxd), 16'h0000);
        check(16'(pin_out.rxer), 16'h0001);
    endtask

    initial begin
        #(25 * 6000);
        n_mismatch++;
        print_verdict();
    end
    initial begin
        test_reset_straps(PAT_B);
        test_reset_straps(PAT_A);
        test_irq();
        test_wake();
        test_rx();
        check(16'(strap_out), 16'(strap_of(PAT_A)));
        print_verdict();
    end
endmodule // test_psm_pin_mux
